// >>> inc/rsmc_pkg.sv
// Package for the reference switch monitor configuration block.
// Assumes a single 20 MHz system clock and an APB register port.
`default_nettype none
package rsmc_pkg;
  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] CFG_ADDR     = 8'h00; // Monitor switch config
  localparam logic [7:0] IRQ_STS_ADDR = 8'h04; // Sticky event status
  localparam logic [7:0] IRQ_MSK_ADDR = 8'h08; // Event mask
  localparam logic [7:0] STATE_ADDR   = 8'h0C; // Live selection state
  localparam logic [7:0] PRIO_ADDR    = 8'h10; // Priorities of I3..I6

  // ********************************************************************
  // Config field positions and reset value
  // ********************************************************************
  localparam int          TDO_FLAG_BIT   = 6;
  localparam int          ULTRA_FAST_BIT = 5;
  localparam int          EXT_SW_BIT     = 4;
  localparam int          PBO_HOLD_BIT   = 3;
  localparam int          BUILDOUT_BIT   = 2;
  localparam logic [7:0]  CFG_RESET      = 8'h05;
  localparam logic [2:0]  MISS_LIMIT     = 3'h2; // Missing cycles to fail

  // ********************************************************************
  // Sources and events
  // ********************************************************************
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_I3   = 3'h3;
  localparam logic [2:0] SRC_I4   = 3'h4;
  localparam logic [2:0] SRC_I5   = 3'h5;
  localparam logic [2:0] SRC_I6   = 3'h6;
  localparam int EV_REF_FAIL = 0;
  localparam int EV_SRC_CHG  = 1;
  localparam int EV_PBO      = 2;

  typedef enum logic [1:0] {
    RSMC_FREE = 2'b00,
    RSMC_LOCK = 2'b01,
    RSMC_HOLD = 2'b11
  } rsmc_mode_e;
endpackage
`default_nettype wire

// >>> src/rsmc_top.sv
// Monitor and source switch configuration with forced external selection.
// Assumes an APB master on core_clk; loop status comes from same domain
// except the select pin and reference activity, which are synchronised.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (RL1) With the test-output bit set, the scan data pin copies the reference fail status bit.
// (RL2) With that bit clear, the scan data pin carries the normal boundary-scan data.
// (RL3) With ultra-fast switching on, the selected reference fails within under three missed cycles.
// (RL4) With ultra-fast switching off, only activity or frequency monitors fail the reference.
// (RL5) External switching mode restricts locking to the pair chosen by the select pin.
// (RL6) External switching mode forces the operating state to locked.
// (RL7) Select high locks I3 if its priority is non-zero, else I5.
// (RL8) Select low locks I4 if its priority is non-zero, else I6.
// (RL9) The external switching enable resets to the level of the strap pin at power-up.
// (RL10) The phase build-out hold bit keeps the phase and blocks further build-out events.
// (RL11) Build-out disabled without hold makes the loop re-lock its phase to zero.
// (RL12) With build-out enabled and the hold bit clear, every new source selection fires a build-out event.
// (RL13) The select pin is synchronised before it drives the forced selection.
module rsmc_top
  import rsmc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        source_select_pin,
  input  wire logic        source_select_strap,
  input  wire logic        scan_tdo_in,
  output logic             scan_tdo_out,
  // Loop side
  input  wire logic        ref_activity,
  input  wire logic        monitor_fail,
  input  wire logic        auto_lock,
  input  wire logic [2:0]  auto_source,
  output logic [2:0]       sel_source,
  output logic [1:0]       op_mode,
  output logic             phase_zero_relock,
  output logic             pbo_event,
  output logic             irq
);
  import rsmc_pkg::*;

  // ********************************************************************
  // Storage
  // ********************************************************************
  logic [7:0]  cfg_ff;
  logic [2:0]  sts_ff;
  logic [2:0]  msk_ff;
  logic [15:0] prio_ff;
  logic        strap_done_ff;
  logic [1:0]  sel_sync_ff;
  logic [1:0]  strap_sync_ff;
  logic [2:0]  act_sync_ff;
  logic [2:0]  miss_ff;
  logic [5:0]  idle_ff;
  logic        ref_fail_ff;
  logic [2:0]  nxt_source;
  logic        ext_mode;
  logic        wr_en;
  logic        src_change;
  logic        fast_fail;
  logic [2:0]  events;

  assign wr_en    = psel && penable && pwrite;
  assign ext_mode = cfg_ff[EXT_SW_BIT];

  // Two-flop synchroniser for the select pin, three-flop for reference activity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_sync_ff   <= 2'h0;
      act_sync_ff   <= 3'h0;
    end else begin
      sel_sync_ff   <= {sel_sync_ff[0], source_select_pin}; // RL13
      act_sync_ff   <= {act_sync_ff[1:0], ref_activity};
    end
  end

  // Strap synchroniser, no reset so it is settled when reset ends
  always_ff @(posedge core_clk) begin
    strap_sync_ff <= {strap_sync_ff[0], source_select_strap}; // RL9
  end

  // ********************************************************************
  // Registers and APB
  // ********************************************************************
  // Config register, strap loaded once after reset release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_ff        <= CFG_RESET;
      strap_done_ff <= 1'b0;
    end else if (!strap_done_ff) begin
      strap_done_ff      <= 1'b1;
      cfg_ff[EXT_SW_BIT] <= strap_sync_ff[1]; // RL9
    end else if (wr_en && paddr == CFG_ADDR) begin
      cfg_ff <= pwdata[7:0];
    end
  end

  // Priorities and mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prio_ff <= 16'h0000;
      msk_ff  <= 3'h0;
    end else if (wr_en) begin
      if (paddr == PRIO_ADDR) prio_ff <= pwdata[15:0];
      if (paddr == IRQ_MSK_ADDR) msk_ff <= pwdata[2:0];
    end
  end

  // Sticky status, set wins over write-one-clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sts_ff <= 3'h0;
    end else if (wr_en && paddr == IRQ_STS_ADDR) begin
      sts_ff <= (sts_ff & ~pwdata[2:0]) | events;
    end else begin
      sts_ff <= sts_ff | events;
    end
  end

  // Read data, ready and error
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          CFG_ADDR:     prdata <= {24'h000000, cfg_ff};
          IRQ_STS_ADDR: prdata <= {29'h00000000, sts_ff};
          IRQ_MSK_ADDR: prdata <= {29'h00000000, msk_ff};
          STATE_ADDR:   prdata <= {27'h0000000, op_mode, sel_source};
          PRIO_ADDR:    prdata <= {16'h0000, prio_ff};
          default:      pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ********************************************************************
  // Reference monitoring
  // ********************************************************************
  // Missed cycle counter on the selected reference activity
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle_ff <= 6'h00;
      miss_ff <= 3'h0;
    end else if (act_sync_ff[2] != act_sync_ff[1]) begin
      idle_ff <= 6'h00;
      miss_ff <= 3'h0;
    end else if (idle_ff == 6'h3F) begin
      idle_ff <= 6'h00;
      if (miss_ff != 3'h7) miss_ff <= miss_ff + 3'h1;
    end else begin
      idle_ff <= idle_ff + 6'h01;
    end
  end

  assign fast_fail = cfg_ff[ULTRA_FAST_BIT] && (miss_ff >= MISS_LIMIT); // RL3

  // Reference failure flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ref_fail_ff <= 1'b0;
    else     ref_fail_ff <= monitor_fail || fast_fail; // RL4
  end

  // ********************************************************************
  // Source selection
  // ********************************************************************
  // Forced pair or automatic choice
  always_comb begin
    nxt_source = ref_fail_ff ? SRC_NONE : auto_source;
    if (ext_mode) begin
      if (sel_sync_ff[1]) nxt_source = (prio_ff[3:0] != 4'h0) ? SRC_I3 : SRC_I5;   // RL7
      else                nxt_source = (prio_ff[7:4] != 4'h0) ? SRC_I4 : SRC_I6;   // RL8
    end
  end

  assign src_change = (nxt_source != sel_source) && (nxt_source != SRC_NONE);

  // Selected source and operating mode
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_source <= SRC_NONE;
      op_mode    <= RSMC_FREE;
    end else begin
      sel_source <= nxt_source; // RL5
      if (ext_mode)      op_mode <= RSMC_LOCK; // RL6
      else if (auto_lock && !ref_fail_ff) op_mode <= RSMC_LOCK;
      else if (op_mode == RSMC_LOCK) op_mode <= RSMC_HOLD;
      else op_mode <= op_mode;
    end
  end

  assign events = {src_change && cfg_ff[BUILDOUT_BIT] && !cfg_ff[PBO_HOLD_BIT],
                   src_change, ref_fail_ff};

  // ********************************************************************
  // Phase build-out, scan pin, interrupt
  // ********************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pbo_event         <= 1'b0;
      phase_zero_relock <= 1'b0;
      scan_tdo_out      <= 1'b0;
      irq               <= 1'b0;
    end else begin
      pbo_event         <= events[EV_PBO]; // RL12 RL10
      phase_zero_relock <= !cfg_ff[BUILDOUT_BIT] && !cfg_ff[PBO_HOLD_BIT]; // RL11
      scan_tdo_out      <= cfg_ff[TDO_FLAG_BIT] ? sts_ff[EV_REF_FAIL] : scan_tdo_in; // RL1 RL2
      irq               <= |(sts_ff & msk_ff);
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  chk_ext_pair_high: assert property (@(posedge core_clk) disable iff (rst) // RL7
    ext_mode && sel_sync_ff[1] |=> (sel_source == SRC_I3 || sel_source == SRC_I5))
    else $error("forced pair high wrong");
  chk_ext_pair_low: assert property (@(posedge core_clk) disable iff (rst) // RL8
    ext_mode && !sel_sync_ff[1] && prio_ff[7:4] == 4'h0 |=> sel_source == SRC_I6)
    else $error("forced pair low wrong");
  chk_ext_mode_lock: assert property (@(posedge core_clk) disable iff (rst) // RL6
    ext_mode |=> op_mode == RSMC_LOCK) else $error("ext mode not locked");
  chk_tdo_mirror: assert property (@(posedge core_clk) disable iff (rst) // RL1
    cfg_ff[TDO_FLAG_BIT] |=> scan_tdo_out == $past(sts_ff[EV_REF_FAIL]))
    else $error("tdo not mirroring");
  chk_tdo_normal: assert property (@(posedge core_clk) disable iff (rst) // RL2
    !rst && !cfg_ff[TDO_FLAG_BIT] |=> scan_tdo_out == $past(scan_tdo_in))
    else $error("tdo not normal");
  chk_fast_fail: assert property (@(posedge core_clk) disable iff (rst) // RL3
    fast_fail |=> ref_fail_ff ##1 sel_source == SRC_NONE || ext_mode)
    else $error("fast fail missed");
  chk_slow_only: assert property (@(posedge core_clk) disable iff (rst) // RL4
    !cfg_ff[ULTRA_FAST_BIT] && !monitor_fail |=> !ref_fail_ff)
    else $error("spurious failure");
  chk_hold_blocks: assert property (@(posedge core_clk) disable iff (rst) // RL10
    cfg_ff[PBO_HOLD_BIT] |=> !pbo_event) else $error("build-out while held");
  chk_pbo_fire: assert property (@(posedge core_clk) disable iff (rst) // RL12
    src_change && cfg_ff[BUILDOUT_BIT] && !cfg_ff[PBO_HOLD_BIT] |=> pbo_event)
    else $error("build-out event missed");
  chk_zero_relock: assert property (@(posedge core_clk) disable iff (rst) // RL11
    !cfg_ff[BUILDOUT_BIT] && !cfg_ff[PBO_HOLD_BIT] |=> phase_zero_relock)
    else $error("zero relock missing");

  // Steps of a register access and of the strap load
  sequence s_apb_setup;
    psel && !penable;
  endsequence
  sequence s_apb_answer;
    pready ##1 !pready;
  endsequence
  sequence s_strap_wait;
    !rst && !strap_done_ff;
  endsequence

  // Register port and power-up strap
  chk_apb_answer: assert property (@(posedge core_clk) disable iff (rst)
    s_apb_setup |=> s_apb_answer) else $error("register answer not one cycle");
  chk_strap_load: assert property (@(posedge core_clk) disable iff (rst) // RL9
    s_strap_wait |=> cfg_ff[EXT_SW_BIT] == $past(strap_sync_ff[1]))
    else $error("strap not loaded");
  chk_sticky_fail: assert property (@(posedge core_clk) disable iff (rst) // RL1
    ref_fail_ff |=> sts_ff[EV_REF_FAIL]) else $error("fail status not set");

  // Forced selection with programmed priority
  chk_ext_high_i3: assert property (@(posedge core_clk) disable iff (rst) // RL7
    ext_mode && sel_sync_ff[1] && prio_ff[3:0] != 4'h0 |=> sel_source == SRC_I3)
    else $error("forced high choice missed");
  chk_ext_low_i4: assert property (@(posedge core_clk) disable iff (rst) // RL8
    ext_mode && !sel_sync_ff[1] && prio_ff[7:4] != 4'h0 |=> sel_source == SRC_I4)
    else $error("forced low choice missed");

  // Ultra-fast limit, build-out, relock, scan pin
  chk_fast_limit: assert property (@(posedge core_clk) disable iff (rst) // RL3
    cfg_ff[ULTRA_FAST_BIT] && miss_ff == MISS_LIMIT |=> ref_fail_ff)
    else $error("fail later than limit");
  chk_hold_relock: assert property (@(posedge core_clk) disable iff (rst) // RL10
    cfg_ff[PBO_HOLD_BIT] |=> !phase_zero_relock) else $error("relock while held");
  chk_pbo_quiet: assert property (@(posedge core_clk) disable iff (rst) // RL12
    !src_change |=> !pbo_event) else $error("build-out event without new source");
  chk_tdo_fail: assert property (@(posedge core_clk) disable iff (rst) // RL1
    cfg_ff[TDO_FLAG_BIT] && sts_ff[EV_REF_FAIL] |=> scan_tdo_out) else $error("tdo fail low");

  // Interrupt level follows enabled status
  chk_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    (|(sts_ff & msk_ff)) |=> irq) else $error("interrupt not raised");
  chk_irq_quiet: assert property (@(posedge core_clk) disable iff (rst)
    !(|(sts_ff & msk_ff)) |=> !irq) else $error("interrupt without cause");
endmodule // rsmc_top
`default_nettype wire

// >>> verif/test_reference_switch_monitor_config.sv
// Self-checking bench for the monitor switch configuration block.
// Assumes rsmc_pkg and rsmc_top are compiled first; APB master at 20 MHz.
`timescale 1ns/100ps
`default_nettype none
module test_reference_switch_monitor_config;
  import rsmc_pkg::*;
  // ******************************************************************
  // Signals and instance
  // ******************************************************************
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        sel_pin, strap, tdo_in, tdo_out, ref_act, mon_fail, act_en;
  logic        auto_lock, relock, pbo_ev, irq;
  logic [2:0]  auto_src, sel_src;
  logic [1:0]  op_mode;
  logic [3:0]  act_cnt;
  int          miscompares, checks;
  rsmc_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .source_select_pin(sel_pin),
    .source_select_strap(strap), .scan_tdo_in(tdo_in), .scan_tdo_out(tdo_out),
    .ref_activity(ref_act), .monitor_fail(mon_fail), .auto_lock(auto_lock),
    .auto_source(auto_src), .sel_source(sel_src), .op_mode(op_mode),
    .phase_zero_relock(relock), .pbo_event(pbo_ev), .irq(irq));
  // Clock source
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Reference activity, one toggle every 16 clocks
  always @(posedge core_clk) begin
    act_cnt <= act_cnt + 4'h1;
    if (act_en && act_cnt == 4'hF) ref_act <= ~ref_act;
  end
  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
    end
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulses(output int n);
    n = 0;
    repeat (8) begin
      @(negedge core_clk);
      if (pbo_ev === 1'b1) n++;
    end
  endtask
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_reset();
    apb(1'b0, CFG_ADDR, 32'h0);
    cmp(rdv, {24'h0, CFG_RESET});
    apb(1'b0, 8'h14, 32'h0);
    cmp(err, 1'b1);
    cmp(rdv, 32'h0);
    tdo_in <= 1'b1;
    cyc(2);
    @(negedge core_clk);
    cmp(tdo_out, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_pbo();
    int n;
    @(posedge core_clk);
    auto_lock <= 1'b1;
    auto_src <= SRC_I4;
    pulses(n);
    cmp(n, 1);
    apb(1'b1, CFG_ADDR, 32'h0D);
    auto_src <= SRC_I5;
    pulses(n);
    cmp(n, 0);
    apb(1'b1, CFG_ADDR, 32'h01);
    cyc(2);
    @(negedge core_clk);
    cmp(relock, 1'b1);
    apb(1'b1, CFG_ADDR, 32'h09);
    cyc(2);
    @(negedge core_clk);
    cmp(relock, 1'b0);
    $display("build-out test done");
  endtask
  task automatic t_fail();
    apb(1'b1, IRQ_STS_ADDR, 32'h7);
    act_en <= 1'b0;
    cyc(200);
    apb(1'b0, IRQ_STS_ADDR, 32'h0);
    cmp(rdv[0], 1'b0);
    act_en <= 1'b1;
    apb(1'b1, CFG_ADDR, 32'h25);
    cyc(40);
    apb(1'b1, IRQ_STS_ADDR, 32'h7);
    apb(1'b0, IRQ_STS_ADDR, 32'h0);
    cmp(rdv[0], 1'b0);
    act_en <= 1'b0;
    cyc(180);
    apb(1'b0, IRQ_STS_ADDR, 32'h0);
    cmp(rdv[0], 1'b1);
    apb(1'b1, CFG_ADDR, 32'h65);
    cyc(2);
    @(negedge core_clk);
    cmp(tdo_out, 1'b1);
    apb(1'b1, IRQ_MSK_ADDR, 32'h0);
    cyc(2);
    @(negedge core_clk);
    cmp(irq, 1'b0);
    apb(1'b1, IRQ_MSK_ADDR, 32'h7);
    cyc(2);
    @(negedge core_clk);
    cmp(irq, 1'b1);
    act_en <= 1'b1;
    cyc(40);
    apb(1'b1, IRQ_STS_ADDR, 32'h7);
    cyc(2);
    @(negedge core_clk);
    cmp({tdo_out, irq}, 2'b00);
    $display("failure test done");
  endtask
  task automatic t_ext();
    logic [15:0] pr [4] = '{16'h0001, 16'h0010, 16'h0010, 16'h0001};
    logic [2:0]  ex [4] = '{SRC_I3, SRC_I5, SRC_I4, SRC_I6};
    int          i;
    @(posedge core_clk);
    auto_lock <= 1'b0;
    auto_src <= SRC_NONE;
    apb(1'b1, CFG_ADDR, 32'h15);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, PRIO_ADDR, {16'h0, pr[i]});
      sel_pin <= (i < 2);
      cyc(4);
      @(negedge core_clk);
      cmp({op_mode, sel_src}, {RSMC_LOCK, ex[i]});
    end
    apb(1'b0, STATE_ADDR, 32'h0);
    cmp(rdv, {27'h0, RSMC_LOCK, SRC_I6});
    $display("external switch test done");
  endtask
  task automatic t_strap();
    strap <= 1'b1;
    cyc(3);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(2);
    apb(1'b0, CFG_ADDR, 32'h0);
    cmp(rdv, {24'h0, CFG_RESET} | (32'h1 << EXT_SW_BIT));
    apb(1'b0, STATE_ADDR, 32'h0);
    cmp(rdv, {27'h0, RSMC_LOCK, SRC_I6});
    $display("strap test done");
  endtask
  // Main sequence
  initial begin
    {rst, act_en} = 2'b11;
    {psel, penable, pwrite, sel_pin, strap, tdo_in, mon_fail, auto_lock} = 8'h00;
    {paddr, pwdata, auto_src, act_cnt, ref_act} = '0;
    {miscompares, checks} = '0;
    cyc(8);
    rst <= 1'b0;
    cyc(2);
    t_reset();
    t_pbo();
    t_fail();
    t_ext();
    t_strap();
    report_and_stop();
  end
endmodule // test_reference_switch_monitor_config
`default_nettype wire
